// ==== include/motor_option_pkg.sv ====
// Purpose: Shared constants and carriers for the motor option configuration bank
// Assumes: 25 MHz core clock, byte-wide register port from the serial engine
// Notes:   Register reset values are plain defaults
package motor_option_pkg;
    // ==========================================================
    // Register offsets and reset values
    localparam logic [7:0] ADDR_ACCEL    = 8'h28;
    localparam logic [7:0] ADDR_DEADTIME = 8'h29;
    localparam logic [7:0] ADDR_SENSE    = 8'h2A;
    localparam logic [7:0] ADDR_FEEDBACK = 8'h2B;
    localparam logic [7:0] RST_ACCEL     = 8'h00;
    localparam logic [7:0] RST_DEADTIME  = 8'h00;
    localparam logic [7:0] RST_SENSE     = 8'h00;
    localparam logic [7:0] RST_FEEDBACK  = 8'h00;
    localparam logic [7:0] ACCEL_MASK    = 8'hFE;
    // ==========================================================
    // Field positions
    localparam int ACCEL_LIM_LSB = 4;
    localparam int LOCK_LIM_LSB  = 1;
    localparam int CL_LOCK_BIT   = 7;
    localparam int CL_ACCEL_LSB  = 4;
    localparam int DEADTIME_LSB  = 0;
    localparam int IPD_THR_LSB   = 4;
    localparam int OL_LOCK_BIT   = 3;
    localparam int VREG_BIT      = 2;
    localparam int IPD_RATE_LSB  = 0;
    localparam int FB_GATE_LSB   = 6;
    localparam int FB_RATIO_LSB  = 4;
    localparam int KT_WIN_LSB    = 2;
    localparam int SPD_MODE_BIT  = 1;
    localparam int CL_DIS_BIT    = 0;
    // ==========================================================
    // Scales and timing
    localparam logic [11:0] ACCEL_STEP_MA  = 12'h0C8;
    localparam logic [11:0] LOCK_STEP_MA   = 12'h190;
    localparam logic [11:0] IPD_STEP_MA    = 12'h0C8;
    localparam logic [12:0] TH_RANGE0_DHZ  = 13'h0008;
    localparam logic [12:0] TH_RANGE1_DHZ  = 13'h0080;
    localparam int CLK_HZ           = 25_000_000;
    localparam int CLK_NS           = 40;
    localparam int DEADTIME_STEP_NS = 40;
    localparam int DT_STEP_CYC = (DEADTIME_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int IPD_HZ_0 = 12;
    localparam int IPD_HZ_1 = 24;
    localparam int IPD_HZ_2 = 47;
    localparam int IPD_HZ_3 = 95;
    localparam int IPD_CYC_0 = CLK_HZ / IPD_HZ_0;
    localparam int IPD_CYC_1 = CLK_HZ / IPD_HZ_1;
    localparam int IPD_CYC_2 = CLK_HZ / IPD_HZ_2;
    localparam int IPD_CYC_3 = CLK_HZ / IPD_HZ_3;
    localparam int ZC_TIMEOUT_MS  = 1000;
    localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_MS * (CLK_HZ / 1000);
    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        accel_limit_en;
        logic [11:0] accel_limit_ma;
        logic [11:0] lock_limit_ma;
        logic        lock_closed_en;
        logic        lock_open_en;
        logic        accel_unlimited;
        logic [2:0]  accel_rate_code;
        logic [4:0]  deadtime_cycles;
        logic        ipd_en;
        logic [11:0] ipd_thr_ma;
        logic        vreg_3v3;
        logic [1:0]  ipd_rate;
        logic [1:0]  fb_gate;
        logic [1:0]  fb_ratio;
        logic        kt_high_x2;
        logic        kt_low_half;
        logic        speed_pwm_mode;
        logic        closed_loop_disable;
    } settings_t;
endpackage : motor_option_pkg

// ==== rtl/motor_option_config_bank.sv ====
// Purpose: Four option registers and the logic they steer directly
// Assumes: Serial engine presents one-cycle byte read and write strobes
// Notes:   Currents in mA, speeds in 0.1 Hz units
`timescale 1ns/1ns
`default_nettype none
module motor_option_config_bank
    import motor_option_pkg::*;
#(
    parameter int IPD_PERIOD_0 = IPD_CYC_0,
    parameter int IPD_PERIOD_1 = IPD_CYC_1,
    parameter int IPD_PERIOD_2 = IPD_CYC_2,
    parameter int IPD_PERIOD_3 = IPD_CYC_3,
    parameter int ZC_TIMEOUT   = ZC_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire reg_req_t    reg_req_i,
    output logic [7:0]       reg_rdata_o,
    // Motor engine status
    input  wire logic        closed_loop_i,
    input  wire logic        first_open_loop_i,
    input  wire logic        zero_cross_i,
    input  wire logic        elec_cycle_i,
    input  wire logic [4:0]  op2cl_code_i,
    input  wire logic [12:0] speed_dhz_i,
    input  wire logic [2:0]  hs_cmd_i,
    // Steered outputs
    output settings_t        settings_o,
    output logic [2:0]       hs_o,
    output logic [2:0]       ls_o,
    output logic             ipd_tick_o,
    output logic             speed_feedback_o,
    output logic             lock_closed_o,
    output logic             lock_open_o,
    output logic             go_closed_o,
    output logic [12:0]      op2cl_dhz_o
);
    logic [7:0] accel_reg;
    logic [7:0] deadtime_reg;
    logic [7:0] sense_reg;
    logic [7:0] feedback_reg;

    // ==========================================================
    // Register writes and reads
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            accel_reg    <= RST_ACCEL;
            deadtime_reg <= RST_DEADTIME;
            sense_reg    <= RST_SENSE;
            feedback_reg <= RST_FEEDBACK;
        end else if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                ADDR_ACCEL:    accel_reg    <= reg_req_i.wdata & ACCEL_MASK;
                ADDR_DEADTIME: deadtime_reg <= reg_req_i.wdata;
                ADDR_SENSE:    sense_reg    <= reg_req_i.wdata;
                ADDR_FEEDBACK: feedback_reg <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                ADDR_ACCEL:    reg_rdata_o <= accel_reg;
                ADDR_DEADTIME: reg_rdata_o <= deadtime_reg;
                ADDR_SENSE:    reg_rdata_o <= sense_reg;
                ADDR_FEEDBACK: reg_rdata_o <= feedback_reg;
                default:       reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Field decode
    function automatic settings_t decode(input logic [7:0] r0, input logic [7:0] r1,
                                         input logic [7:0] r2, input logic [7:0] r3);
        settings_t s;
        s = '0;
        s.accel_limit_en  = (r0[ACCEL_LIM_LSB +: 4] != 4'h0);
        s.accel_limit_ma  = 12'(r0[ACCEL_LIM_LSB +: 4]) * ACCEL_STEP_MA;
        s.lock_limit_ma   = (12'(r0[LOCK_LIM_LSB +: 3]) + 12'h001) * LOCK_STEP_MA;
        s.lock_closed_en  = r1[CL_LOCK_BIT];
        s.accel_unlimited = (r1[CL_ACCEL_LSB +: 3] == 3'h0);
        s.accel_rate_code = r1[CL_ACCEL_LSB +: 3];
        s.deadtime_cycles = 5'((5'(r1[DEADTIME_LSB +: 4]) + 5'h01) * 5'(DT_STEP_CYC));
        s.ipd_en          = (r2[IPD_THR_LSB +: 4] != 4'h0);
        s.ipd_thr_ma      = (12'(r2[IPD_THR_LSB +: 4]) + 12'h001) * IPD_STEP_MA;
        s.lock_open_en    = r2[OL_LOCK_BIT];
        s.vreg_3v3        = r2[VREG_BIT];
        s.ipd_rate        = r2[IPD_RATE_LSB +: 2];
        s.fb_gate         = r3[FB_GATE_LSB +: 2];
        s.fb_ratio        = r3[FB_RATIO_LSB +: 2];
        s.kt_high_x2      = r3[KT_WIN_LSB];
        s.kt_low_half     = r3[KT_WIN_LSB + 1];
        s.speed_pwm_mode  = r3[SPD_MODE_BIT];
        s.closed_loop_disable = r3[CL_DIS_BIT];
        return s;
    endfunction : decode

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            settings_o <= decode(RST_ACCEL, RST_DEADTIME, RST_SENSE, RST_FEEDBACK);
        end else begin
            settings_o <= decode(accel_reg, deadtime_reg, sense_reg, feedback_reg);
        end
    end

    // ==========================================================
    // Dead time per phase
    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            logic       applied;
            logic [4:0] dt_cnt;
            // Both gates off for dead time
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    applied   <= 1'b0;
                    dt_cnt    <= 5'h00;
                    hs_o[ph]  <= 1'b0;
                    ls_o[ph]  <= 1'b0;
                end else if (hs_cmd_i[ph] != applied) begin
                    applied   <= hs_cmd_i[ph];
                    dt_cnt    <= 5'h01;
                    hs_o[ph]  <= 1'b0;
                    ls_o[ph]  <= 1'b0;
                end else if (dt_cnt != 5'h00 && dt_cnt < settings_o.deadtime_cycles) begin
                    dt_cnt    <= dt_cnt + 5'h01;
                end else begin
                    dt_cnt    <= 5'h00;
                    hs_o[ph]  <= applied;
                    ls_o[ph]  <= ~applied;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Inductive sense clock
    logic [21:0] ipd_cnt;
    logic [21:0] ipd_period;
    always_comb begin
        unique case (settings_o.ipd_rate)
            2'h0: ipd_period = 22'(IPD_PERIOD_0);
            2'h1: ipd_period = 22'(IPD_PERIOD_1);
            2'h2: ipd_period = 22'(IPD_PERIOD_2);
            2'h3: ipd_period = 22'(IPD_PERIOD_3);
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i || !settings_o.ipd_en) begin
            ipd_cnt    <= 22'h000000;
            ipd_tick_o <= 1'b0;
        end else if (ipd_cnt >= ipd_period - 22'h000001) begin
            ipd_cnt    <= 22'h000000;
            ipd_tick_o <= 1'b1;
        end else begin
            ipd_cnt    <= ipd_cnt + 22'h000001;
            ipd_tick_o <= 1'b0;
        end
    end

    // ==========================================================
    // Speed feedback output
    logic [1:0] fb_cnt;
    logic       fb_emit;
    logic       fb_allow;
    always_comb begin
        unique case (settings_o.fb_ratio)
            2'h0: fb_emit = 1'b1;
            2'h1: fb_emit = (fb_cnt != 2'h2);
            2'h2: fb_emit = (fb_cnt == 2'h0);
            2'h3: fb_emit = (fb_cnt == 2'h0);
        endcase
        unique case (settings_o.fb_gate)
            2'h0: fb_allow = 1'b1;
            2'h1: fb_allow = closed_loop_i;
            2'h2: fb_allow = closed_loop_i || first_open_loop_i;
            2'h3: fb_allow = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fb_cnt           <= 2'h0;
            speed_feedback_o <= 1'b0;
        end else begin
            speed_feedback_o <= elec_cycle_i && fb_emit && fb_allow;
            if (elec_cycle_i) begin
                // Cycle count wraps at two or three
                if (fb_cnt == 2'h2 || (settings_o.fb_ratio == 2'h2 && fb_cnt == 2'h1)) begin
                    fb_cnt <= 2'h0;
                end else begin
                    fb_cnt <= fb_cnt + 2'h1;
                end
            end
        end
    end

    // ==========================================================
    // Stuck detection, one timer per loop state
    logic [24:0] zc_timer [2];
    logic [1:0]  zc_loop;
    assign zc_loop = {closed_loop_i, !closed_loop_i};
    genvar li;
    generate
        for (li = 0; li < 2; li++) begin : g_stuck
            // Timer restarts on each zero cross
            always_ff @(posedge mclk_i) begin
                if (rst_i || zero_cross_i || !zc_loop[li]) begin
                    zc_timer[li] <= 25'h0000000;
                end else if (zc_timer[li] < 25'(ZC_TIMEOUT)) begin
                    zc_timer[li] <= zc_timer[li] + 25'h0000001;
                end
            end
        end
    endgenerate

    // Timeout is long so one missed edge does not trip a lock
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            lock_closed_o <= 1'b0;
            lock_open_o   <= 1'b0;
        end else begin
            lock_closed_o <= settings_o.lock_closed_en && closed_loop_i
                             && (zc_timer[1] >= 25'(ZC_TIMEOUT)) && !zero_cross_i;
            lock_open_o   <= settings_o.lock_open_en && !closed_loop_i
                             && (zc_timer[0] >= 25'(ZC_TIMEOUT)) && !zero_cross_i;
        end
    end

    // ==========================================================
    // Open to closed loop transfer
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            op2cl_dhz_o <= 13'h0000;
            go_closed_o <= 1'b0;
        end else begin
            if (op2cl_code_i[4]) begin
                op2cl_dhz_o <= 13'((13'(op2cl_code_i[3:0]) + 13'h0001) * TH_RANGE1_DHZ);
            end else begin
                op2cl_dhz_o <= 13'(13'(op2cl_code_i[3:0]) * TH_RANGE0_DHZ);
            end
            go_closed_o <= !settings_o.closed_loop_disable && (op2cl_dhz_o != 13'h0000)
                           && (speed_dhz_i >= op2cl_dhz_o);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_accel_write;
        reg_req_i.wr && reg_req_i.addr == ADDR_ACCEL;
    endsequence

    a_accel_limit_scale: assert property (
        s_accel_write |-> ##2 settings_o.accel_limit_ma == 12'($past(reg_req_i.wdata[7:4], 2))
            * ACCEL_STEP_MA && settings_o.accel_limit_en == ($past(reg_req_i.wdata[7:4], 2) != 0))
        else $error("accel limit decode wrong");

    a_lock_limit_scale: assert property (
        s_accel_write |-> ##2 settings_o.lock_limit_ma
            == (12'($past(reg_req_i.wdata[3:1], 2)) + 12'h001) * LOCK_STEP_MA)
        else $error("lock limit decode wrong");

    a_closed_stuck_cause: assert property (
        lock_closed_o |-> $past(settings_o.lock_closed_en) && $past(closed_loop_i)
            && !$past(zero_cross_i))
        else $error("closed loop lock without cause");

    a_deadtime_gap: assert property (
        $changed(hs_cmd_i[0]) |=> !hs_o[0] && !ls_o[0])
        else $error("gates not off after command change");

    a_gate_no_overlap: assert property (
        $rose(hs_o[0]) |-> $past(!ls_o[0]) && $past(!hs_o[0]))
        else $error("high side rose without gap");

    a_sense_idle: assert property (
        ipd_tick_o |-> $past(settings_o.ipd_en))
        else $error("sense tick while disabled");

    a_vreg_select: assert property (
        reg_req_i.wr && reg_req_i.addr == ADDR_SENSE |-> ##2
            settings_o.vreg_3v3 == $past(reg_req_i.wdata[2], 2))
        else $error("regulator select not applied");

    a_feedback_reserved: assert property (
        $past(settings_o.fb_gate) == 2'h3 |-> !speed_feedback_o)
        else $error("feedback pulse in reserved gating");

    a_no_transfer_disabled: assert property (
        go_closed_o |-> !$past(settings_o.closed_loop_disable))
        else $error("closed loop transfer while disabled");

    a_unused_bit_zero: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_ACCEL |=> reg_rdata_o[0] == 1'b0)
        else $error("unused bit reads one");

    a_threshold_range1: assert property (
        op2cl_code_i == 5'h1F |=> op2cl_dhz_o == 13'(2048))
        else $error("threshold range one wrong");
endmodule : motor_option_config_bank
`default_nettype wire

// ==== test/config_host_model.sv ====
// Purpose: Host model issuing byte register cycles
// Assumes: One-cycle strobes, read data stands after the taking edge
// Notes:   Released address and data show inverted last values
`timescale 1ns/1ns
`default_nettype none
module config_host_model
    import motor_option_pkg::*;
(
    // Clock
    input  wire logic       mclk_i,
    // Register port
    output reg_req_t        req_o,
    input  wire logic [7:0] rdata_i
);
    initial req_o = '0;
    // ==========
    // Bus cycle
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        @(posedge mclk_i);
        q = rdata_i;
    endtask : xfer
endmodule : config_host_model
`default_nettype wire

// ==== test/motor_option_config_bank_tb.sv ====
// Purpose: Self-checking bench for the option bank
// Assumes: Short sense periods and lock timeout
// Notes:   Host model drives the register port
`timescale 1ns/1ns
`default_nettype none
module motor_option_config_bank_tb;
    import motor_option_pkg::*;
    logic        mclk = 0, rst = 1, cl = 0, fo = 0, zc = 0, ec = 0;
    logic [4:0]  code = '0;
    logic [12:0] spd = '0;
    logic [2:0]  cmd = '0;
    logic [7:0]  rdata, q;
    reg_req_t    req;
    settings_t   st;
    logic [2:0]  hs, ls;
    logic        tick, fb, lkc, lko, goc;
    logic [12:0] thr;
    int          failures = 0, cmp_count = 0, n, t0, t1, fb_n = 0;
    // Register images 0x28..0x2B
    logic [31:0] img [3] = '{32'hFFA55BF3, 32'h00000408, 32'h121EE664};
    int          per [4] = '{40, 20, 10, 5};
    logic [3:0]  dts [2] = '{4'h0, 4'h9};
    // Feedback rows: gate, ratio, closed, first open, pulses per six cycles
    logic [8:0]  fbt [9] = '{9'h006, 9'h024, 9'h043, 9'h062, 9'h080,
                             9'h096, 9'h10E, 9'h100, 9'h190};
    // Transfer rows: code, speed, disable, threshold with go flag
    logic [4:0]  tc [5] = '{5'h05, 5'h05, 5'h10, 5'h1F, 5'h00};
    logic [12:0] ts [5] = '{13'h0028, 13'h0027, 13'h00C8, 13'h0800, 13'h0064};
    logic [4:0]  td = 5'h08;
    logic [13:0] tx [5] = '{14'h0051, 14'h0050, 14'h0101, 14'h1000, 14'h0000};

    always #20 mclk = ~mclk;
    always @(posedge mclk) fb_n <= fb_n + (fb === 1'b1);

    config_host_model host (.mclk_i(mclk), .req_o(req), .rdata_i(rdata));
    motor_option_config_bank #(.IPD_PERIOD_0(40), .IPD_PERIOD_1(20), .IPD_PERIOD_2(10),
        .IPD_PERIOD_3(5), .ZC_TIMEOUT(50)) dut (
        .mclk_i(mclk), .rst_i(rst), .reg_req_i(req), .reg_rdata_o(rdata),
        .closed_loop_i(cl), .first_open_loop_i(fo), .zero_cross_i(zc),
        .elec_cycle_i(ec), .op2cl_code_i(code), .speed_dhz_i(spd),
        .hs_cmd_i(cmd), .settings_o(st), .hs_o(hs), .ls_o(ls),
        .ipd_tick_o(tick), .speed_feedback_o(fb), .lock_closed_o(lkc),
        .lock_open_o(lko), .go_closed_o(goc), .op2cl_dhz_o(thr));

    // ==========
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
    endtask : cyc
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    function automatic settings_t exp_set(input logic [31:0] r);
        settings_t s;
        s.accel_limit_en = |r[31:28];
        s.accel_limit_ma = {8'h00, r[31:28]} * ACCEL_STEP_MA;
        s.lock_limit_ma = ({9'h000, r[27:25]} + 12'h001) * LOCK_STEP_MA;
        s.lock_closed_en = r[23];
        s.accel_unlimited = r[22:20] == 3'h0;
        s.accel_rate_code = r[22:20];
        s.deadtime_cycles = {1'b0, r[19:16]} + 5'h01;
        s.ipd_en = |r[15:12];
        s.ipd_thr_ma = ({8'h00, r[15:12]} + 12'h001) * IPD_STEP_MA;
        s.lock_open_en = r[11];
        s.vreg_3v3 = r[10];
        s.ipd_rate = r[9:8];
        s.fb_gate = r[7:6];
        s.fb_ratio = r[5:4];
        s.kt_high_x2 = r[2];
        s.kt_low_half = r[3];
        s.speed_pwm_mode = r[1];
        s.closed_loop_disable = r[0];
        return s;
    endfunction : exp_set
    task automatic chk_set(input logic [31:0] r);
        cmp_count++;
        if (st !== exp_set(r)) begin
            failures++;
            $display("[FAIL] settings expected %h seen %h", exp_set(r), st);
        end
    endtask : chk_set

    // ==========
    // Watchdog, generous over the fewer than a thousand cycles of tests
    initial begin
        #2_000_000;
        failures++;
        final_report();
    end

    initial begin
        cyc(6);
        rst <= 1'b0;
        // ==========
        // Register image rows
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 4; k++) wr(8'h28 + 8'(k), img[i][31-8*k -: 8]);
            for (int k = 0; k < 4; k++) begin
                host.xfer(1'b0, 8'h28 + 8'(k), 8'h00, q);
                chk("readback", {24'h0, img[i][31-8*k -: 8] & (k == 0 ? ACCEL_MASK : 8'hFF)},
                    {24'h0, q});
            end
            cyc(2);
            chk_set(img[i]);
        end
        // ==========
        // Dead time gap, second value is the 400 ns advice
        foreach (dts[j]) begin
            wr(8'h29, {4'h0, dts[j]});
            cyc(2);
            for (int s = 0; s < 2; s++) begin
                @(posedge mclk);
                cmd <= {2'b00, s == 0};
                n = 0;
                repeat (30) begin
                    @(posedge mclk);
                    #1;
                    if (hs[0] === 1'b0 && ls[0] === 1'b0) n++;
                end
                chk("gap cycles", 32'(dts[j]) + 1, n);
                chk("new side", {31'h0, s == 0}, {31'h0, hs[0]});
                chk("low sides", {29'h0, 2'b11, s != 0}, {29'h0, ls});
            end
        end
        // ==========
        // Sense tick period per rate code, then none when off
        for (int r = 0; r < 4; r++) begin
            wr(8'h2A, {6'h04, 2'(r)});
            t0 = -1;
            t1 = -1;
            for (int c = 0; c < 120 && t1 < 0; c++) begin
                @(posedge mclk);
                #1;
                if (tick === 1'b1 && t0 < 0) t0 = c;
                else if (tick === 1'b1) t1 = c;
            end
            chk("sense period", per[r], t1 - t0);
        end
        wr(8'h2A, 8'h03);
        n = 0;
        repeat (100) begin
            @(posedge mclk);
            #1;
            if (tick !== 1'b0) n++;
        end
        chk("sense off", 0, n);
        // ==========
        // Feedback gating and ratio rows
        foreach (fbt[i]) begin
            wr(8'h2B, {fbt[i][8:5], 4'h0});
            cl <= fbt[i][4];
            fo <= fbt[i][3];
            cyc(2);
            n = fb_n;
            repeat (6) begin
                @(posedge mclk);
                ec <= 1'b1;
                @(posedge mclk);
                ec <= 1'b0;
            end
            cyc(3);
            chk("feedback pulses", 32'(fbt[i][2:0]), fb_n - n);
        end
        // ==========
        // Lock detection in each loop state
        wr(8'h2A, 8'h08);
        cl <= 1'b0;
        cyc(60);
        chk("open lock", 2, {lko, lkc});
        zc <= 1'b1;
        @(posedge mclk);
        zc <= 1'b0;
        cyc(2);
        chk("open lock cleared", 0, {31'h0, lko});
        wr(8'h2A, 8'h00);
        wr(8'h29, 8'h80);
        cl <= 1'b1;
        cyc(60);
        chk("closed lock", 1, {lko, lkc});
        // ==========
        // Open to closed transfer rows
        foreach (tc[i]) begin
            wr(8'h2B, {7'h00, td[i]});
            code <= tc[i];
            spd <= ts[i];
            cyc(4);
            chk("threshold", tx[i][13:1], thr);
            chk("go closed", tx[i][0], goc);
        end
        // ==========
        // Mid-run reset, reset values and unmapped place
        rst <= 1'b1;
        cyc(6);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            host.xfer(1'b0, 8'h28 + 8'(k), 8'h00, q);
            chk("reset value", 0, {24'h0, q});
        end
        chk_set(32'h0);
        wr(8'h30, 8'h5A);
        host.xfer(1'b0, 8'h30, 8'h00, q);
        chk("unmapped read", 0, {24'h0, q});
        final_report();
    end
endmodule : motor_option_config_bank_tb
`default_nettype wire
